// File: pkg/prc_regs.svh
// Offsets, count ranges, reset values and timing counts of the configurator
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
`define PRC_CLK_NS 20
`define PRC_OFF_US 30
`define PRC_STORE_US 26
`define PRC_NEG_DELAY_MS 10
`define PRC_OFF_CYC (`PRC_OFF_US * 1000 / `PRC_CLK_NS)
`define PRC_STORE_CYC (`PRC_STORE_US * 1000 / `PRC_CLK_NS)
`define PRC_NEG_DELAY_CYC (`PRC_NEG_DELAY_MS * 1000000 / `PRC_CLK_NS)
`define PRC_ADDR_STATUS 4'h0
`define PRC_ADDR_SETTINGS 4'h4
`define PRC_ADDR_CONTROL 4'h8
`define PRC_ADDR_LAST 4'hC
`define PRC_NEG_FIRST 7'h01
`define PRC_NEG_LAST 7'h33
`define PRC_NEG_DEF 6'h19
`define PRC_AUX_FIRST 7'h34
`define PRC_AUX_LAST 7'h4F
`define PRC_AUX_DEF 5'h08
`define PRC_DIS_ON 7'h50
`define PRC_DIS_OFF 7'h51
`define PRC_DET_ON 7'h52
`define PRC_DET_OFF 7'h53
`define PRC_POS_FIRST 7'h54
`define PRC_POS_LAST 7'h5A
`define PRC_POS_DEF 3'h0
`define PRC_OCP_FIRST 7'h5B
`define PRC_OCP_LAST 7'h62
`define PRC_OCP_DEF 3'h0
`define PRC_CNT_MAX 7'h7F
`endif

// File: pkg/prc_pkg.sv
// Types shared by the rail configurator
package prc_pkg;
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_ON = 4'h2,
		ST_LOW = 4'h4,
		ST_HIGH = 4'h8
	} prc_state_e;
	typedef struct packed {
		logic [5:0] neg_code;
		logic [2:0] pos_code;
		logic [4:0] aux_code;
		logic [2:0] ocp_code;
		logic dis_off;
		logic det_on;
	} prc_set_s;
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} prc_req_s;
endpackage

// File: hdl/prc_configurator.sv
// Pulse-count rail configurator with Avalon-MM status and control
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`include "prc_regs.svh"
module prc_configurator
#(
	parameter int P_NEG_DELAY_CYC = `PRC_NEG_DELAY_CYC
)
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ctrl_pin,
	input wire logic i_aux_en_pin,
	input wire logic i_discharge_select_pin,
	input wire logic i_sense_absent,
	input wire logic i_sense_gap_above_hi,
	input wire logic i_sense_gap_below_lo,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_pos_rail_en,
	output logic o_neg_rail_en,
	output logic o_aux_rail_en,
	output logic [5:0] o_neg_code,
	output logic [2:0] o_pos_code,
	output logic [4:0] o_aux_code,
	output logic [2:0] o_ocp_code,
	output logic o_det_on,
	output logic o_panel_discharge,
	output logic o_aux_discharge,
	output logic o_panel_hiz,
	output logic o_aux_hiz,
	output logic o_sense_use_pin
);
	localparam int NPIN = 6;
	localparam logic [10:0] OFF_CYC = 11'(`PRC_OFF_CYC);
	localparam logic [10:0] STORE_CYC = 11'(`PRC_STORE_CYC);
	localparam logic [18:0] NEG_CYC = 19'(P_NEG_DELAY_CYC);
	logic [NPIN-1:0] pins;
	logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
	assign pins = {i_sense_gap_below_lo, i_sense_gap_above_hi, i_sense_absent,
		i_discharge_select_pin, i_aux_en_pin, i_ctrl_pin};
	// A level counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_sync
			always_ff @(posedge i_sys_clk)
			begin
				s1_reg[g] <= pins[g];
				s2_reg[g] <= s1_reg[g];
				s3_reg[g] <= s2_reg[g];
				if (i_reset)
					filt_reg[g] <= 1'b0;
				else if (s2_reg[g] == s3_reg[g])
					filt_reg[g] <= s3_reg[g];
			end
		end
	endgenerate
	wire ctrl_lvl = filt_reg[0];
	wire aux_lvl = filt_reg[1];
	wire dsel_lvl = filt_reg[2];
	wire sense_absent = filt_reg[3];
	wire gap_hi = filt_reg[4];
	wire gap_lo = filt_reg[5];
	logic ctrl_d_reg;
	wire ctrl_rise = ctrl_lvl & ~ctrl_d_reg;
	wire ctrl_fall = ~ctrl_lvl & ctrl_d_reg;

	prc_pkg::prc_state_e state_reg, state_next;
	prc_pkg::prc_set_s set_reg, set_next, set_def;
	logic [6:0] cnt_reg, last_reg;
	logic [10:0] tmr_reg;
	logic [18:0] neg_tmr_reg;
	logic neg_en_reg, inhibit_reg, sense_pin_reg;
	logic [31:0] rdata_reg;
	logic ack_reg;

	assign set_def = '{neg_code: `PRC_NEG_DEF, pos_code: `PRC_POS_DEF,
		aux_code: `PRC_AUX_DEF, ocp_code: `PRC_OCP_DEF, dis_off: 1'b0,
		det_on: 1'b0};
	wire off_done = (tmr_reg == OFF_CYC - 11'h001);
	wire store_done = (tmr_reg == STORE_CYC - 11'h001);
	wire apply = (state_reg == prc_pkg::ST_HIGH) & ctrl_lvl & store_done;
	wire shut = (state_reg == prc_pkg::ST_LOW) & ~ctrl_lvl & off_done;
	wire in_neg = cnt_reg >= `PRC_NEG_FIRST && cnt_reg <= `PRC_NEG_LAST;
	wire in_aux = cnt_reg >= `PRC_AUX_FIRST && cnt_reg <= `PRC_AUX_LAST;
	wire in_pos = cnt_reg >= `PRC_POS_FIRST && cnt_reg <= `PRC_POS_LAST;
	wire in_ocp = cnt_reg >= `PRC_OCP_FIRST && cnt_reg <= `PRC_OCP_LAST;
	wire [6:0] aux_off = cnt_reg - `PRC_AUX_FIRST;
	wire [6:0] pos_off = cnt_reg - `PRC_POS_FIRST;
	wire [6:0] ocp_off = cnt_reg - `PRC_OCP_FIRST;
	wire all_low = ~ctrl_lvl & ~aux_lvl & (state_reg == prc_pkg::ST_OFF);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			prc_pkg::ST_OFF: if (ctrl_rise) state_next = prc_pkg::ST_ON;
			prc_pkg::ST_ON: if (ctrl_fall) state_next = prc_pkg::ST_LOW;
			prc_pkg::ST_LOW:
				if (ctrl_rise)
					state_next = prc_pkg::ST_HIGH;
				else if (shut)
					state_next = prc_pkg::ST_OFF;
			prc_pkg::ST_HIGH:
				if (ctrl_fall)
					state_next = prc_pkg::ST_LOW;
				else if (apply)
					state_next = prc_pkg::ST_ON;
			default: state_next = prc_pkg::ST_OFF;
		endcase
	end

	always_comb
	begin
		set_next = set_reg;
		if (all_low)
			set_next = set_def;
		else if (shut)
		begin
			set_next.neg_code = `PRC_NEG_DEF;
			set_next.pos_code = `PRC_POS_DEF;
		end
		else if (apply)
		begin
			// counts outside every range fall through unchanged
			if (in_neg)
				set_next.neg_code = cnt_reg[5:0];
			else if (in_aux)
				set_next.aux_code = aux_off[4:0];
			else if (cnt_reg == `PRC_DIS_ON)
				set_next.dis_off = 1'b0;
			else if (cnt_reg == `PRC_DIS_OFF)
				set_next.dis_off = 1'b1;
			else if (cnt_reg == `PRC_DET_ON)
				set_next.det_on = 1'b1;
			else if (cnt_reg == `PRC_DET_OFF)
				set_next.det_on = 1'b0;
			else if (in_pos)
				set_next.pos_code = pos_off[2:0];
			else if (in_ocp)
				set_next.ocp_code = ocp_off[2:0];
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			state_reg <= prc_pkg::ST_OFF;
			set_reg <= '{neg_code: `PRC_NEG_DEF, pos_code: `PRC_POS_DEF,
				aux_code: `PRC_AUX_DEF, ocp_code: `PRC_OCP_DEF,
				dis_off: 1'b0, det_on: 1'b0};
			ctrl_d_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			set_reg <= set_next;
			ctrl_d_reg <= ctrl_lvl;
		end
	end

	// Edge counter and phase timer
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			cnt_reg <= 7'h00;
			tmr_reg <= 11'h000;
			last_reg <= 7'h00;
		end
		else
		begin
			if (state_reg == prc_pkg::ST_ON && ctrl_fall)
				cnt_reg <= 7'h00;
			else if (state_reg == prc_pkg::ST_LOW && ctrl_rise
				&& cnt_reg != `PRC_CNT_MAX)
				cnt_reg <= cnt_reg + 7'h01;
			if (ctrl_rise || ctrl_fall)
				tmr_reg <= 11'h000;
			else if (tmr_reg != 11'h7FF)
				tmr_reg <= tmr_reg + 11'h001;
			if (apply)
				last_reg <= cnt_reg;
		end
	end

	// Negative rail waits a fixed delay after the positive rail comes up
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset || !o_pos_rail_en)
		begin
			neg_tmr_reg <= 19'h00000;
			neg_en_reg <= 1'b0;
		end
		else if (neg_tmr_reg == NEG_CYC - 19'h00001)
			neg_en_reg <= 1'b1;
		else
			neg_tmr_reg <= neg_tmr_reg + 19'h00001;
	end

	// Hysteresis: between the two thresholds the last choice holds
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			sense_pin_reg <= 1'b0;
		else if (sense_absent || gap_hi)
			sense_pin_reg <= 1'b0;
		else if (gap_lo)
			sense_pin_reg <= 1'b1;
	end

	assign o_pos_rail_en = (state_reg != prc_pkg::ST_OFF) & ~inhibit_reg;
	assign o_neg_rail_en = neg_en_reg;
	assign o_aux_rail_en = aux_lvl & ~inhibit_reg;
	assign o_neg_code = set_reg.neg_code;
	assign o_pos_code = set_reg.pos_code;
	assign o_aux_code = set_reg.aux_code;
	assign o_ocp_code = set_reg.ocp_code;
	assign o_det_on = set_reg.det_on;
	assign o_sense_use_pin = sense_pin_reg;
	wire dis_allowed = dsel_lvl & ~set_reg.dis_off;
	assign o_panel_discharge = dis_allowed & ~o_pos_rail_en;
	assign o_aux_discharge = dis_allowed & ~o_aux_rail_en;
	assign o_panel_hiz = ~o_pos_rail_en & ~o_panel_discharge;
	assign o_aux_hiz = ~o_aux_rail_en & ~o_aux_discharge;

	// Avalon slave: every access waits exactly one cycle
	prc_pkg::prc_req_s req;
	assign req = '{address: i_avs_address, read: i_avs_read,
		write: i_avs_write, writedata: i_avs_writedata};
	wire req_new = (req.read | req.write) & ~ack_reg;
	assign o_avs_waitrequest = (req.read | req.write) & ~ack_reg;
	assign o_avs_readdata = rdata_reg;
	wire [31:0] status_word = {20'h00000, state_reg, 1'b0, dsel_lvl, aux_lvl,
		ctrl_lvl, sense_pin_reg, neg_en_reg, o_aux_rail_en, o_pos_rail_en};
	wire [31:0] settings_word = {13'h0000, set_reg};
	wire [31:0] rmux = (req.address == `PRC_ADDR_STATUS) ? status_word :
		(req.address == `PRC_ADDR_SETTINGS) ? settings_word :
		(req.address == `PRC_ADDR_CONTROL) ? {31'h00000000, inhibit_reg} :
		(req.address == `PRC_ADDR_LAST) ? {25'h0000000, last_reg} :
		32'h00000000;
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			inhibit_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= req_new;
			if (req_new && req.read)
				rdata_reg <= rmux;
			if (ack_reg && req.write && req.address == `PRC_ADDR_CONTROL)
				inhibit_reg <= req.writedata[0];
		end
	end

	property p_neg_delay;
		@(posedge i_sys_clk) disable iff (i_reset)
		$rose(o_pos_rail_en) |-> !o_neg_rail_en [*8];
	endproperty
	a_neg_delay: assert property (p_neg_delay) else $error("neg early");
	property p_neg_off;
		@(posedge i_sys_clk) disable iff (i_reset)
		!o_pos_rail_en |=> !o_neg_rail_en;
	endproperty
	a_neg_off: assert property (p_neg_off) else $error("neg rail alone");
	property p_shutdown;
		@(posedge i_sys_clk) disable iff (i_reset)
		shut |=> state_reg == prc_pkg::ST_OFF && o_neg_code == `PRC_NEG_DEF
			&& o_pos_code == `PRC_POS_DEF;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("no restore");
	property p_start;
		@(posedge i_sys_clk) disable iff (i_reset)
		state_reg == prc_pkg::ST_OFF && ctrl_rise && !inhibit_reg
			|=> o_pos_rail_en && o_pos_code == `PRC_POS_DEF;
	endproperty
	a_start: assert property (p_start) else $error("pos rail not started");
	property p_neg_code;
		@(posedge i_sys_clk) disable iff (i_reset)
		apply && in_neg && !all_low |=> o_neg_code == $past(cnt_reg[5:0]);
	endproperty
	a_neg_code: assert property (p_neg_code) else $error("neg code wrong");
	property p_fd_off;
		@(posedge i_sys_clk) disable iff (i_reset)
		apply && cnt_reg == `PRC_DIS_OFF
			|=> set_reg.dis_off && !o_panel_discharge && !o_aux_discharge;
	endproperty
	a_fd_off: assert property (p_fd_off) else $error("discharge kept");
	property p_ignore;
		@(posedge i_sys_clk) disable iff (i_reset)
		apply && cnt_reg > `PRC_OCP_LAST |=> $stable(set_reg);
	endproperty
	a_ignore: assert property (p_ignore) else $error("bad count applied");
	property p_clear;
		@(posedge i_sys_clk) disable iff (i_reset)
		state_reg == prc_pkg::ST_ON && ctrl_fall |=> cnt_reg == 7'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("count carried");
	property p_hiz;
		@(posedge i_sys_clk) disable iff (i_reset)
		!dsel_lvl && !o_pos_rail_en |-> o_panel_hiz && !o_panel_discharge;
	endproperty
	a_hiz: assert property (p_hiz) else $error("not high impedance");
	property p_sense;
		@(posedge i_sys_clk) disable iff (i_reset)
		gap_hi ##1 gap_hi |-> !o_sense_use_pin;
	endproperty
	a_sense: assert property (p_sense) else $error("sense pin kept");
	c_apply: cover property (@(posedge i_sys_clk) apply && in_neg);
	c_shut: cover property (@(posedge i_sys_clk) shut);
	c_neg_on: cover property (@(posedge i_sys_clk) $rose(o_neg_rail_en));
endmodule // prc_configurator

// File: tb/prc_host_model.sv
// Host GPIO model that drives pulse bursts on the configuration pin
`timescale 1ns/100ps
module prc_host_model
(
	input wire logic i_clk,
	output logic o_ctrl_pin
)
;
	// Fastest legal phase keeps the long bursts inside the run budget
	localparam int PHASE_CYC = 100;
	localparam int STORE_CYC = 1500;
	initial o_ctrl_pin = 1'b0;
	// Call just after a rising edge: drives then holds for cyc edges
	task automatic hold(input logic v, input int cyc);
	begin
		o_ctrl_pin <= v;
		repeat (cyc) @(posedge i_clk);
	end
	endtask
	task automatic burst(input int n);
	begin
		for (int i = 0; i < n; i++)
		begin
			hold(1'b0, PHASE_CYC);
			hold(1'b1, PHASE_CYC);
		end
		hold(1'b1, STORE_CYC - PHASE_CYC);
	end
	endtask
endmodule // prc_host_model

// File: tb/tb.sv
// Self-checking bench for the pulse-count rail configurator
`timescale 1ns/100ps
`include "prc_regs.svh"
module tb;
	logic clk, rst, aux_en, dsel, s_abs, s_hi, s_lo, rd, wr;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, q;
	logic pos_en, neg_en, aux_on, det, p_dis, a_dis, p_hiz, a_hiz, use_pin;
	logic wait_req, ctrl;
	logic [5:0] neg;
	logic [2:0] pos, ocp;
	logic [4:0] aux;
	prc_pkg::prc_set_s exp;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	int counts [5] = '{2, 52, 85, 92, 99};
	prc_host_model i_host (.i_clk(clk), .o_ctrl_pin(ctrl));
	prc_configurator #(.P_NEG_DELAY_CYC(50)) i_dut (.i_sys_clk(clk),
		.i_reset(rst), .i_ctrl_pin(ctrl), .i_aux_en_pin(aux_en),
		.i_discharge_select_pin(dsel), .i_sense_absent(s_abs),
		.i_sense_gap_above_hi(s_hi), .i_sense_gap_below_lo(s_lo),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req), .o_pos_rail_en(pos_en),
		.o_neg_rail_en(neg_en), .o_aux_rail_en(aux_on), .o_neg_code(neg),
		.o_pos_code(pos), .o_aux_code(aux), .o_ocp_code(ocp), .o_det_on(det),
		.o_panel_discharge(p_dis), .o_aux_discharge(a_dis),
		.o_panel_hiz(p_hiz), .o_aux_hiz(a_hiz), .o_sense_use_pin(use_pin));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic tally_and_finish();
	begin
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	// Bursts run at the minimum phase, so the whole run is near 96k cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 98000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
	begin
		comparisons++;
		if (seen !== want)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				want);
		end
	end
	endtask
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d);
	begin
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		@(posedge clk);
		while (wait_req !== 1'b0) @(posedge clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		// An idle edge keeps a following call from retoggling in one step
		@(posedge clk);
	end
	endtask
	task automatic chk_set();
	begin
		check(neg, exp.neg_code);
		check(pos, exp.pos_code);
		check(aux, exp.aux_code);
		check(ocp, exp.ocp_code);
		check(det, exp.det_on);
		av(1'b0, `PRC_ADDR_SETTINGS, 32'h0);
		check(q[18:0], exp);
	end
	endtask
	task automatic step(input int n);
	begin
		repeat (n) @(posedge clk);
	end
	endtask
	task automatic defaults();
	begin
		exp = '0;
		exp.neg_code = `PRC_NEG_DEF;
		exp.aux_code = `PRC_AUX_DEF;
	end
	endtask
	initial
	begin
		{aux_en, dsel, s_hi, s_lo, rd, wr} = '0;
		s_abs = 1'b1;
		addr = 4'h0;
		wdata = 32'h0;
		rst = 1'b1;
		defaults();
		step(2);
		rst <= 1'b0;
		step(8);
		check({pos_en, neg_en, aux_on}, 3'h0);
		check({p_hiz, a_hiz, p_dis}, 3'h6);
		chk_set();
		check(use_pin, 1'b0);
		s_abs <= 1'b0;
		s_lo <= 1'b1;
		dsel <= 1'b1;
		aux_en <= 1'b1;
		step(8);
		check(use_pin, 1'b1);
		check({p_dis, a_hiz}, 2'h2);
		check({aux_on, pos_en}, 2'h2);
		s_lo <= 1'b0;
		s_hi <= 1'b1;
		i_host.hold(1'b1, 8);
		check(use_pin, 1'b0);
		check({pos_en, neg_en, pos}, 5'h10);
		step(60);
		check(neg_en, 1'b1);
		for (int i = 0; i < 5; i++)
		begin
			i_host.burst(counts[i]);
			if (counts[i] <= 51)
				exp.neg_code = 6'(counts[i]);
			else if (counts[i] <= 79)
				exp.aux_code = 5'(counts[i] - 52);
			else if (counts[i] >= 84 && counts[i] <= 90)
				exp.pos_code = 3'(counts[i] - 84);
			else if (counts[i] >= 91 && counts[i] <= 98)
				exp.ocp_code = 3'(counts[i] - 91);
			chk_set();
		end
		av(1'b0, `PRC_ADDR_LAST, 32'h0);
		check(q[6:0], 7'h63);
		av(1'b0, 4'h2, 32'h0);
		check(q, 32'h0);
		av(1'b1, `PRC_ADDR_SETTINGS, 32'h0007FFFF);
		chk_set();
		av(1'b1, `PRC_ADDR_CONTROL, 32'h1);
		check({pos_en, aux_on}, 2'h0);
		av(1'b0, `PRC_ADDR_CONTROL, 32'h0);
		check(q, 32'h1);
		av(1'b1, `PRC_ADDR_CONTROL, 32'h0);
		check({pos_en, neg_en, aux_on}, 3'h5);
		i_host.hold(1'b0, 1600);
		check({pos_en, neg_en, p_dis}, 3'h1);
		exp.neg_code = `PRC_NEG_DEF;
		exp.pos_code = `PRC_POS_DEF;
		chk_set();
		i_host.hold(1'b1, 100);
		i_host.burst(`PRC_DIS_OFF);
		exp.dis_off = 1'b1;
		chk_set();
		i_host.hold(1'b0, 1600);
		check({p_dis, p_hiz}, 2'h1);
		aux_en <= 1'b0;
		step(8);
		defaults();
		chk_set();
		check({aux_on, p_dis, a_dis}, 3'h3);
		i_host.hold(1'b1, 100);
		i_host.burst(1);
		check(neg, 6'h01);
		rst <= 1'b1;
		step(2);
		rst <= 1'b0;
		step(1);
		chk_set();
		tally_and_finish();
	end
endmodule // tb
